// [core/ata_idgeo.sv]
/*
 * Command logic for the upper identification words, the set-geometry
 * command and the recalibrate command of a parallel disk drive.
 * Assumes an APB master on sys_clk, and a seek engine on the same clock
 * that answers a seek request with a one-cycle done pulse.
 */
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module ata_idgeo
    import ata_idgeo_pkg::*;
#(
    parameter logic [27:0] CAPACITY = 28'h0100000
) (
    input  wire logic      sys_clk,
    input  wire logic      reset,
    input  wire apb_req_t  apb_req,
    output apb_rsp_t       apb_rsp,
    output logic           intrq,
    output logic           busy,
    output logic           seek_req,
    output logic [15:0]    seek_cyl,
    input  wire seek_rsp_t seek_rsp
);

    // All state of the block in one record
    typedef struct packed {
        fsm_t        fsm;
        logic        bsy;
        logic        err;
        logic        intrq;
        logic [7:0]  err_reg;
        logic [7:0]  idx;
        logic [7:0]  sect_cnt;
        logic [7:0]  drv_head;
        logic [15:0] feat_en;
        logic [7:0]  config_r;
        logic [15:0] secur;
        logic [7:0]  geo_spt;
        logic [3:0]  geo_hd;
        logic [15:0] cyl;
        logic [13:0] rem;
        logic [27:0] quo;
        logic [13:0] dvs;
        logic [4:0]  cnt;
        logic        seek_req;
        logic [15:0] seek_cyl;
        apb_rsp_t    rsp;
    } state_t;

    // Registered state and its next value
    state_t st_r;
    state_t st_nxt;

    // Bus phase decode and divider datapath
    logic        acc_done;
    logic        wr_done;
    logic        rd_done;
    logic        setup;
    logic [15:0] id_word;
    logic [1:0]  udma_mode;
    logic        udma_ok;
    logic [13:0] trial;
    logic        fits;
    logic [12:0] divisor;

    // A transfer completes at the edge where pready is seen with the access phase
    assign setup    = apb_req.psel && !apb_req.penable;
    assign acc_done = apb_req.psel && apb_req.penable && st_r.rsp.pready;
    assign wr_done  = acc_done && apb_req.pwrite;
    assign rd_done  = acc_done && !apb_req.pwrite;

    // A stale mode above 2 must not light a reserved select bit
    assign udma_mode = st_r.config_r[CFG_UDMA_LO +: 2];
    assign udma_ok   = st_r.config_r[CFG_BIT_UDMA_OK] && (udma_mode <= UDMA_MAX_MODE);

    // Sectors per track times head count; the field holds heads minus one
    assign divisor = 13'(st_r.sect_cnt * ({1'b0, st_r.drv_head[3:0]} + 5'd1));

    // Cylinders are capacity over sectors times heads; the host waits on busy,
    // so a slow bit-serial quotient costs nothing visible
    // One restoring-division step per cycle keeps the multiplier count at one
    assign trial = {st_r.rem[12:0], st_r.quo[27]};
    assign fits  = (trial >= st_r.dvs);

    // Identification word selected by the current index
    always_comb begin
        id_word = 16'h0000;
        case (st_r.idx)
            // Validity flag for the Ultra DMA word
            W_VALID53: begin
                id_word[W53_BIT_UDMA] = udma_ok;
            end

            // Supported sets: signature plus microcode support
            W_CMDSUP: begin
                id_word    = SIG_PATTERN;
                id_word[0] = st_r.config_r[CFG_BIT_UCODE];
            end

            // Extensions carry the signature only
            W_CMDEXT: begin
                id_word = SIG_PATTERN;
            end

            // Enabled features come straight from the host's register
            W_CMDEN: begin
                id_word = st_r.feat_en;
            end

            // Enabled sets: signature plus microcode support
            W_CMDEN2: begin
                id_word    = SIG_PATTERN;
                id_word[0] = st_r.config_r[CFG_BIT_UCODE];
            end

            // Third enabled word carries the signature only
            W_CMDEN3: begin
                id_word = SIG_PATTERN;
            end

            // Support bits are fixed; one select bit only while valid
            W_UDMA: begin
                id_word[2:0] = UDMA_SUPPORT;
                if (udma_ok) begin
                    id_word[UDMA_SEL_LO + 32'(udma_mode)] = 1'b1;
                end
            end

            // Security status, reserved bits masked off
            W_SECUR: begin
                id_word = st_r.secur & SEC_MASK;
            end

            // Spin-up bit reads low while skipping spin-up is enabled
            W_SPINUP: begin
                id_word[0] = !st_r.config_r[CFG_BIT_NOSPIN];
            end

            // Reserved and vendor words stay zero
            default: begin
                id_word = 16'h0000;
            end
        endcase
    end

    // Next-state logic: bus slave, command sequencer and divider
    always_comb begin
        // Hold everything by default; the bus answer is a one-cycle pulse
        st_nxt = st_r;
        st_nxt.rsp.pready  = 1'b0;
        st_nxt.rsp.pslverr = 1'b0;

        // Answer in the first access cycle; read data is prepared at setup
        if (setup) begin
            st_nxt.rsp.pready = 1'b1;
            st_nxt.rsp.prdata = 32'h00000000;
            case (apb_req.paddr)
                OFS_DATA:     st_nxt.rsp.prdata = {16'h0000, id_word};
                OFS_ID_INDEX: st_nxt.rsp.prdata = {24'h000000, st_r.idx};
                OFS_SECT_CNT: st_nxt.rsp.prdata = {24'h000000, st_r.sect_cnt};
                OFS_DRV_HEAD: st_nxt.rsp.prdata = {24'h000000, st_r.drv_head};
                OFS_COMMAND:  st_nxt.rsp.prdata = 32'h00000000;
                OFS_STATUS: begin
                    st_nxt.rsp.prdata[ST_BIT_BSY]  = st_r.bsy;
                    st_nxt.rsp.prdata[ST_BIT_DRDY] = !st_r.bsy;
                    st_nxt.rsp.prdata[ST_BIT_ERR]  = st_r.err;
                end
                OFS_ERROR:    st_nxt.rsp.prdata = {24'h000000, st_r.err_reg};
                OFS_FEAT_EN:  st_nxt.rsp.prdata = {16'h0000, st_r.feat_en};
                OFS_CONFIG:   st_nxt.rsp.prdata = {24'h000000, st_r.config_r};
                OFS_SECURITY: st_nxt.rsp.prdata = {16'h0000, st_r.secur & SEC_MASK};
                OFS_GEOMETRY: st_nxt.rsp.prdata = {4'h0, st_r.geo_hd, st_r.geo_spt, st_r.cyl};
                default:      st_nxt.rsp.pslverr = 1'b1;
            endcase
        end

        // Reading the data port steps through the 256 words, wrapping
        if (rd_done && apb_req.paddr == OFS_DATA) begin
            st_nxt.idx = st_r.idx + 8'd1;
        end

        // Reading status acknowledges the interrupt request
        if (rd_done && apb_req.paddr == OFS_STATUS) begin
            st_nxt.intrq = 1'b0;
        end

        // Task-file writes; the loaded values are the host's to choose
        if (wr_done) begin
            case (apb_req.paddr)
                OFS_ID_INDEX: st_nxt.idx      = apb_req.pwdata[7:0];
                OFS_SECT_CNT: st_nxt.sect_cnt = apb_req.pwdata[7:0];
                OFS_DRV_HEAD: st_nxt.drv_head = apb_req.pwdata[7:0];
                OFS_FEAT_EN:  st_nxt.feat_en  = apb_req.pwdata[15:0];
                OFS_CONFIG:   st_nxt.config_r = apb_req.pwdata[7:0];
                OFS_SECURITY: st_nxt.secur    = apb_req.pwdata[15:0] & SEC_MASK;
                default: begin
                end
            endcase
        end

        case (st_r.fsm)
            S_IDLE: begin
                // A command written while busy is dropped, as on a real drive
                if (wr_done && apb_req.paddr == OFS_COMMAND) begin
                    st_nxt.err     = 1'b0;
                    st_nxt.err_reg = 8'h00;
                    st_nxt.intrq   = 1'b0;
                    // Geometry is latched now; later task-file writes cannot disturb it
                    if (apb_req.pwdata[7:0] == CMD_INIT_PARAMS) begin
                        st_nxt.bsy     = 1'b1;
                        st_nxt.geo_spt = st_r.sect_cnt;
                        st_nxt.geo_hd  = st_r.drv_head[3:0];
                        st_nxt.dvs     = {1'b0, divisor};
                        st_nxt.quo     = CAPACITY;
                        st_nxt.rem     = 14'h0000;
                        st_nxt.cnt     = DIV_STEPS;
                        st_nxt.fsm     = S_DIV;
                    end else if (apb_req.pwdata[7:0] == CMD_RECAL) begin
                        st_nxt.bsy      = 1'b1;
                        st_nxt.seek_req = 1'b1;
                        st_nxt.seek_cyl = 16'h0000; // Always cylinder zero
                        st_nxt.fsm      = S_SEEK;
                    end else begin
                        // Unknown opcode: abort with no busy phase
                        st_nxt.err                  = 1'b1;
                        st_nxt.err_reg[ER_BIT_ABRT] = 1'b1;
                        st_nxt.fsm                  = S_IRQ;
                    end
                end
            end

            // Shift one quotient bit per cycle; 28 steps cover the capacity width
            S_DIV: begin
                st_nxt.quo = {st_r.quo[26:0], fits};
                st_nxt.rem = fits ? (trial - st_r.dvs) : trial;
                st_nxt.cnt = st_r.cnt - 5'd1;
                if (st_r.cnt == 5'd0) begin
                    // A zero divisor is not rejected; it yields the clamp value
                    if (st_r.dvs == 14'h0000 || st_nxt.quo[27:16] != 12'h000) begin
                        st_nxt.cyl = CYL_LIMIT;
                    end else begin
                        st_nxt.cyl = st_nxt.quo[15:0];
                    end
                    st_nxt.fsm = S_DONE;
                end
            end

            S_SEEK: begin
                // Hold the request until the seek engine reports back
                if (seek_rsp.done) begin
                    st_nxt.seek_req = 1'b0;
                    if (seek_rsp.fail) begin
                        st_nxt.err                 = 1'b1;
                        st_nxt.err_reg[ER_BIT_TK0] = 1'b1;
                    end
                    st_nxt.fsm = S_DONE;
                end
            end

            // Drop busy one cycle before raising the interrupt
            S_DONE: begin
                st_nxt.bsy = 1'b0;
                st_nxt.fsm = S_IRQ;
            end

            S_IRQ: begin
                // Set wins over a status read in the same cycle
                st_nxt.bsy   = 1'b0;
                st_nxt.intrq = 1'b1;
                st_nxt.fsm   = S_IDLE;
            end

            // Illegal one-hot code: park idle with busy and the seek request cleared
            default: begin
                st_nxt.fsm      = S_IDLE;
                st_nxt.bsy      = 1'b0;
                st_nxt.seek_req = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_r.fsm      <= S_IDLE;
            st_r.bsy      <= 1'b0;
            st_r.err      <= 1'b0;
            st_r.intrq    <= 1'b0;
            st_r.err_reg  <= 8'h00;
            st_r.idx      <= 8'h00;
            st_r.sect_cnt <= 8'h00;
            st_r.drv_head <= 8'h00;
            st_r.feat_en  <= FEAT_EN_RST;
            st_r.config_r <= CONFIG_RST;
            st_r.secur    <= SEC_RST;
            st_r.geo_spt  <= 8'h00;
            st_r.geo_hd   <= 4'h0;
            st_r.cyl      <= 16'h0000;
            st_r.rem      <= 14'h0000;
            st_r.quo      <= 28'h0000000;
            st_r.dvs      <= 14'h0000;
            st_r.cnt      <= 5'h00;
            st_r.seek_req <= 1'b0;
            st_r.seek_cyl <= 16'h0000;
            st_r.rsp      <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state register
    assign apb_rsp  = st_r.rsp;
    assign intrq    = st_r.intrq;
    assign busy     = st_r.bsy;
    assign seek_req = st_r.seek_req;
    assign seek_cyl = st_r.seek_cyl;

endmodule

`default_nettype wire

// [core/ata_idgeo_pkg.sv]
/*
 * Package for the identification and geometry command block.
 * Holds register offsets, field positions, reset values, command codes
 * and the state encoding. Assumes a 32-bit APB bus with byte addresses.
 */
package ata_idgeo_pkg;

    // Register byte offsets
    localparam logic [7:0]  OFS_DATA      = 8'h00;
    localparam logic [7:0]  OFS_ID_INDEX  = 8'h04;
    localparam logic [7:0]  OFS_SECT_CNT  = 8'h08;
    localparam logic [7:0]  OFS_DRV_HEAD  = 8'h0C;
    localparam logic [7:0]  OFS_COMMAND   = 8'h10;
    localparam logic [7:0]  OFS_STATUS    = 8'h14;
    localparam logic [7:0]  OFS_ERROR     = 8'h18;
    localparam logic [7:0]  OFS_FEAT_EN   = 8'h1C;
    localparam logic [7:0]  OFS_CONFIG    = 8'h20;
    localparam logic [7:0]  OFS_SECURITY  = 8'h24;
    localparam logic [7:0]  OFS_GEOMETRY  = 8'h28;

    // Command codes
    localparam logic [7:0]  CMD_INIT_PARAMS = 8'h91;
    localparam logic [7:0]  CMD_RECAL       = 8'h10;

    // Status and error bit positions
    localparam int          ST_BIT_BSY  = 7;
    localparam int          ST_BIT_DRDY = 6;
    localparam int          ST_BIT_ERR  = 0;
    localparam int          ER_BIT_TK0  = 1;
    localparam int          ER_BIT_ABRT = 2;

    // Configuration register fields
    localparam int          CFG_BIT_UCODE   = 0;
    localparam int          CFG_UDMA_LO     = 1;
    localparam int          CFG_BIT_UDMA_OK = 3;
    localparam int          CFG_BIT_NOSPIN  = 4;

    // Identification word numbers and fixed fields
    localparam logic [7:0]  W_VALID53 = 8'd53;
    localparam logic [7:0]  W_CMDSUP  = 8'd83;
    localparam logic [7:0]  W_CMDEXT  = 8'd84;
    localparam logic [7:0]  W_CMDEN   = 8'd85;
    localparam logic [7:0]  W_CMDEN2  = 8'd86;
    localparam logic [7:0]  W_CMDEN3  = 8'd87;
    localparam logic [7:0]  W_UDMA    = 8'd88;
    localparam logic [7:0]  W_SECUR   = 8'd128;
    localparam logic [7:0]  W_SPINUP  = 8'd131;
    localparam logic [15:0] SIG_PATTERN   = 16'h4000;
    localparam int          UDMA_SEL_LO   = 8;
    localparam logic [2:0]  UDMA_SUPPORT  = 3'h7;
    localparam logic [1:0]  UDMA_MAX_MODE = 2'h2;
    localparam logic [15:0] SEC_MASK      = 16'h011F;
    localparam int          W53_BIT_UDMA  = 2;

    // Reset values and limits
    localparam logic [15:0] FEAT_EN_RST  = 16'h0000;
    localparam logic [7:0]  CONFIG_RST   = 8'h00;
    localparam logic [15:0] SEC_RST      = 16'h0000;
    localparam logic [15:0] CYL_LIMIT    = 16'hFFFF;
    localparam logic [4:0]  DIV_STEPS    = 5'd27;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_DIV  = 5'b00010,
        S_SEEK = 5'b00100,
        S_DONE = 5'b01000,
        S_IRQ  = 5'b10000
    } fsm_t;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic        done;
        logic        fail;
    } seek_rsp_t;

endpackage

// [verification/seek_model.sv]
/* Behavioural seek engine on the far side of the block.
   Assumes the same clock as the block; lag and fail_mode come from the bench. */
`timescale 1ns/10ps
`default_nettype none
module seek_model
    import ata_idgeo_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       seek_req,
    input  wire logic [15:0] seek_cyl,
    input  wire logic [7:0] lag,
    input  wire logic       fail_mode,
    output seek_rsp_t       seek_rsp
);
    logic [7:0] cnt_r;
    // Count lag cycles, then pulse done once; fail shows junk outside done
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_r    <= 8'h00;
            seek_rsp <= '0;
        end else begin
            seek_rsp.done <= 1'b0;
            seek_rsp.fail <= ~fail_mode;
            if (seek_req && !seek_rsp.done) begin
                if (cnt_r == lag) begin
                    seek_rsp.done <= 1'b1;
                    seek_rsp.fail <= fail_mode | (seek_cyl != 16'h0000);
                    cnt_r         <= 8'h00;
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end else begin
                cnt_r <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/ata_idgeo_checker.sv]
/* Port-level assertions for the command block.
   Assumes one clock domain and zero-wait APB answers. */
`timescale 1ns/10ps
`default_nettype none
module ata_idgeo_checker
    import ata_idgeo_pkg::*;
(
    input wire logic      sys_clk,
    input wire logic      reset,
    input wire apb_req_t  apb_req,
    input wire apb_rsp_t  apb_rsp,
    input wire logic      intrq,
    input wire logic      busy,
    input wire logic      seek_req,
    input wire logic [15:0] seek_cyl,
    input wire seek_rsp_t seek_rsp
);
    logic cmd_w;
    // Accepted command write while the block is idle
    assign cmd_w = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
                   && apb_req.paddr == OFS_COMMAND && !busy;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_rdy_pulse; apb_rsp.pready |=> !apb_rsp.pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held too long");
    property p_rdy_ans; apb_req.psel && !apb_req.penable |=> apb_rsp.pready; endproperty
    a_rdy_ans: assert property (p_rdy_ans) else $error("pready missing");
    property p_unmap;
        apb_req.psel && !apb_req.penable && apb_req.paddr > OFS_GEOMETRY
        |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    property p_status;
        apb_rsp.pready && !apb_req.pwrite && $past(apb_req.paddr) == OFS_STATUS
        |-> apb_rsp.prdata[ST_BIT_BSY] == $past(busy)
            && apb_rsp.prdata[ST_BIT_DRDY] != apb_rsp.prdata[ST_BIT_BSY];
    endproperty
    a_status: assert property (p_status) else $error("status bits wrong");
    property p_seek_busy; seek_req |-> busy && seek_cyl == 16'h0000; endproperty
    a_seek_busy: assert property (p_seek_busy) else $error("seek outside busy");
    property p_seek_done;
        seek_req && seek_rsp.done |=> !seek_req ##1 !busy ##1 intrq;
    endproperty
    a_seek_done: assert property (p_seek_done) else $error("seek end order");
    property p_geo;
        cmd_w && apb_req.pwdata[7:0] == CMD_INIT_PARAMS
        |=> busy [*8] ##21 busy ##1 !busy ##1 intrq;
    endproperty
    a_geo: assert property (p_geo) else $error("geometry sequence wrong");
    property p_recal; cmd_w && apb_req.pwdata[7:0] == CMD_RECAL |=> busy && seek_req; endproperty
    a_recal: assert property (p_recal) else $error("recal start wrong");
    property p_abort;
        cmd_w && apb_req.pwdata[7:0] != CMD_RECAL && apb_req.pwdata[7:0] != CMD_INIT_PARAMS
        |=> !busy ##1 intrq;
    endproperty
    a_abort: assert property (p_abort) else $error("abort sequence wrong");
    c_geo: cover property (cmd_w && apb_req.pwdata[7:0] == CMD_INIT_PARAMS);
    c_fail: cover property (seek_rsp.done && seek_rsp.fail);
    c_unmap: cover property (apb_rsp.pslverr);
endmodule
bind ata_idgeo ata_idgeo_checker chk_u (.sys_clk(sys_clk), .reset(reset), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .intrq(intrq), .busy(busy), .seek_req(seek_req), .seek_cyl(seek_cyl),
    .seek_rsp(seek_rsp));
`default_nettype wire

// [verification/tb.sv]
/* Self-checking bench: APB register access, identify table, geometry,
   recalibrate and abort. Assumes the seek model answers the seek port. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ata_idgeo_pkg::*;
    localparam logic [27:0] CAP = 28'h0100000;
    logic        sys_clk, reset, intrq, busy, seek_req, fail_mode;
    logic [15:0] seek_cyl;
    logic [7:0]  lag;
    logic [31:0] q;
    logic        e;
    apb_req_t    req;
    apb_rsp_t    rsp;
    seek_rsp_t   srsp;
    int          n_mismatch, n_checks, i;
    // Identify rows: {config, word index, expected word}
    logic [31:0] rows [23] = '{32'h00350000, 32'h00534000, 32'h00830001, 32'h00580007,
        32'h01534001, 32'h01564001, 32'h01544000, 32'h01574000, 32'h0D580407, 32'h0D350004,
        32'h0A580207, 32'h08580107, 32'h0E580007, 32'h0E350000, 32'h10830000, 32'h0055A5C3,
        32'h0080011F, 32'h007F0000, 32'h00810000, 32'h00840000, 32'h00C80000, 32'h00FF0000,
        32'h00520000};
    logic [15:0] geo [3] = '{16'h1104, 16'h0100, 16'h0003};
    ata_idgeo #(.CAPACITY(CAP)) dut_u (.sys_clk(sys_clk), .reset(reset), .apb_req(req),
        .apb_rsp(rsp), .intrq(intrq), .busy(busy), .seek_req(seek_req),
        .seek_cyl(seek_cyl), .seek_rsp(srsp));
    seek_model sm_u (.sys_clk(sys_clk), .reset(reset), .seek_req(seek_req),
        .seek_cyl(seek_cyl), .lag(lag), .fail_mode(fail_mode), .seek_rsp(srsp));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One APB transfer; answer taken at the rising edge that sees pready, then released
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        @(posedge sys_clk);
        while (rsp.pready !== 1'b1) begin
            @(posedge sys_clk);
        end
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0);
        chk(nm, q, x);
    endtask
    // Issue a command and wait, bounded, for the interrupt
    task automatic cmd(input logic [7:0] c);
        int n;
        apb(OFS_COMMAND, 1'b1, {24'h0, c});
        n = 0;
        while (intrq !== 1'b1 && n < 300) begin
            n++;
            @(negedge sys_clk);
        end
        chk("intrq", {31'h0, intrq}, 32'h1);
    endtask
    function automatic logic [15:0] cyl(input logic [15:0] g);
        logic [31:0] d;
        d = g[15:8] * (g[3:0] + 1);
        if (d == 0 || CAP / d > 65535) return 16'hFFFF;
        return 16'(CAP / d);
    endfunction
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        final_report;
    end
    initial begin
        req = '0;
        lag = 8'h05;
        fail_mode = 1'b0;
        reset = 1'b1;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        rd("config", OFS_CONFIG, 32'h0);
        rd("feat", OFS_FEAT_EN, 32'h0);
        rd("status", OFS_STATUS, 32'h40);
        rd("unmapped", 8'h3C, 32'h0);
        chk("pslverr", {31'h0, e}, 32'h1);
        apb(OFS_FEAT_EN, 1'b1, 32'h0000A5C3);
        apb(OFS_SECURITY, 1'b1, 32'h0000FFFF);
        for (i = 0; i < 23; i++) begin
            apb(OFS_CONFIG, 1'b1, {24'h0, rows[i][31:24]});
            apb(OFS_ID_INDEX, 1'b1, {24'h0, rows[i][23:16]});
            rd("ident", OFS_DATA, {16'h0, rows[i][15:0]});
        end
        apb(OFS_ID_INDEX, 1'b1, 32'h53);
        rd("w83", OFS_DATA, 32'h4000);
        rd("w84", OFS_DATA, 32'h4000);
        for (i = 0; i < 3; i++) begin
            apb(OFS_SECT_CNT, 1'b1, {24'h0, geo[i][15:8]});
            apb(OFS_DRV_HEAD, 1'b1, {24'h0, geo[i][7:0]});
            cmd(CMD_INIT_PARAMS);
            rd("geo", OFS_GEOMETRY, {4'h0, geo[i][3:0], geo[i][15:8], cyl(geo[i])});
            rd("status", OFS_STATUS, 32'h40);
            @(negedge sys_clk);
            chk("intrq clr", {31'h0, intrq}, 32'h0);
        end
        cmd(CMD_RECAL);
        rd("status", OFS_STATUS, 32'h40);
        fail_mode <= 1'b1;
        lag <= 8'h20;
        cmd(CMD_RECAL);
        rd("status", OFS_STATUS, 32'h41);
        rd("error", OFS_ERROR, 32'h2);
        cmd(8'h77);
        rd("error", OFS_ERROR, 32'h4);
        fail_mode <= 1'b0;
        cmd(CMD_RECAL);
        rd("error", OFS_ERROR, 32'h0);
        // Reset in mid-command: busy drops at once, registers return to zero
        apb(OFS_CONFIG, 1'b1, 32'h0000001F);
        apb(OFS_COMMAND, 1'b1, {24'h0, CMD_INIT_PARAMS});
        repeat (3) @(posedge sys_clk);
        chk("busy mid", {31'h0, busy}, 32'h1);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("busy rst", {31'h0, busy}, 32'h0);
        chk("intrq rst", {31'h0, intrq}, 32'h0);
        reset <= 1'b0;
        rd("config rst", OFS_CONFIG, 32'h0);
        rd("geo rst", OFS_GEOMETRY, 32'h0);
        rd("status rst", OFS_STATUS, 32'h40);
        final_report;
    end
endmodule
`default_nettype wire
